// ===== src/sar_pkg.sv
// shared constants and types of the converter serial readout link
package sar_pkg;

	// ==========================================================
	// word and pin levels
	localparam int          DATA_W      = 16;
	localparam int          CNT_W       = 7;
	localparam logic [4:0]  FRAME_BITS  = 5'h10;
	localparam logic        SEL_CS      = 1'b1;
	localparam logic        SEL_DAISY   = 1'b0;

	// ==========================================================
	// timing, figures in ns
	localparam real CLK_PERIOD_NS   = 50.0;
	localparam real T_CONV_MIN_NS   = 500.0;
	localparam real T_CONV_MAX_NS   = 1300.0;
	localparam real T_ACQ_MIN_NS    = 1200.0;
	localparam real T_CYCLE_MIN_NS  = 2500.0;
	localparam real T_SU_DI_CNV_NS  = 7.5;
	localparam real T_SU_CK_CNV_NS  = 5.0;
	localparam real T_EN_MAX_NS     = 12.3;

	// ==========================================================
	// derived cycle counts at CLK
	localparam logic [CNT_W-1:0] DEV_CONV_CYC =
		CNT_W'(int'($ceil(T_CONV_MIN_NS / CLK_PERIOD_NS)));
	localparam logic [CNT_W-1:0] CONV_CYC =
		CNT_W'(int'($ceil(T_CONV_MAX_NS / CLK_PERIOD_NS)));
	localparam logic [CNT_W-1:0] ACQ_CYC =
		CNT_W'(int'($ceil(T_ACQ_MIN_NS / CLK_PERIOD_NS)));
	localparam logic [CNT_W-1:0] CYCLE_CYC =
		CNT_W'(int'($ceil(T_CYCLE_MIN_NS / CLK_PERIOD_NS)));
	localparam real SU_NS = (T_SU_DI_CNV_NS > T_SU_CK_CNV_NS) ?
		T_SU_DI_CNV_NS : T_SU_CK_CNV_NS;
	localparam logic [CNT_W-1:0] SETUP_CYC =
		CNT_W'(int'($ceil(SU_NS / CLK_PERIOD_NS)));
	localparam int EN_FLOOR = int'($floor(T_EN_MAX_NS / CLK_PERIOD_NS));
	localparam logic [CNT_W-1:0] EN_CYC = CNT_W'((EN_FLOOR < 1) ? 1 : EN_FLOOR);
	localparam logic [CNT_W-1:0] SYNC_CYC    = 7'h02;
	localparam logic [CNT_W-1:0] SEL_WAIT_CYC = EN_CYC + SYNC_CYC;

	// ==========================================================
	// host interface modes
	typedef enum logic [1:0] {
		MODE_3WIRE = 2'b00,
		MODE_4WIRE = 2'b01,
		MODE_DAISY = 2'b11
	} sar_mode_type;

	// device conversion engine
	typedef enum logic [1:0] {
		D_ACQ  = 2'b00,
		D_CONV = 2'b01
	} sar_dev_state_type;

	// host sequencer, Gray from IDLE through WAIT; two bits change on the return to IDLE
	typedef enum logic [2:0] {
		H_IDLE  = 3'b000,
		H_SETUP = 3'b001,
		H_CONV  = 3'b011,
		H_SEL   = 3'b010,
		H_SHIFT = 3'b110,
		H_DESEL = 3'b111,
		H_WAIT  = 3'b101
	} sar_host_state_type;

endpackage

// ===== src/sar_link_if.sv
// pins between converter and host controller
`timescale 1ns/1ps
interface sar_link_if;
	logic conversion_start_pin;
	logic sclk;
	logic din;
	logic dout;
	logic dout_oe_n;
	logic dout_line;

	// a released line shows the inverse of dout, so a late sample shows up
	assign dout_line = dout_oe_n ? ~dout : dout;

	modport dev (
		input  conversion_start_pin,
		input  sclk,
		input  din,
		output dout,
		output dout_oe_n
	);

	modport host (
		output conversion_start_pin,
		output sclk,
		output din,
		input  dout_line,
		input  dout_oe_n
	);
endinterface

// ===== src/sar_dev.sv
// converter end: conversion engine on CLK, readout shifter on the link clock
//
// Behaviour
// - 3-wire: start pin low drives MSB out
// - next bit after each falling clock edge
// - 3-wire: release output on deselect or end
// - 4-wire: serial input acts as select
// - 4-wire: input low drives MSB out
// - 4-wire: release on input high or end
// - host holds input high for select modes
// - host holds input low for daisy chain
// - host keeps clock still around start
// - daisy: shift upstream bits through on falling
// - latch input level as mode at start
// - internal clock converts, then track, power down
`timescale 1ns/1ps
module sar_dev
(
	input  wire logic                       CLK,
	input  wire logic                       RESETN,
	sar_link_if.dev                         LINK,
	input  wire logic [sar_pkg::DATA_W-1:0] ANALOG_CODE,
	output logic                            CONV_BUSY,
	output logic                            TRACK_ENABLE,
	output logic                            POWER_DOWN,
	output logic                            MODE_DAISY,
	output logic                            RESULT_READY,
	output logic                            READ_DONE,
	output logic                            START_OVERRUN
);
	import sar_pkg::*;

	// ==========================================================
	// pin synchronisers into CLK
	logic              cnv_s1_ff;
	logic              cnv_s2_ff;
	logic              cnv_s3_ff;
	logic              din_s1_ff;
	logic              din_s2_ff;
	logic              cnv_rise;

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			cnv_s1_ff <= 1'b1;
			cnv_s2_ff <= 1'b1;
			cnv_s3_ff <= 1'b1;
			din_s1_ff <= 1'b1;
			din_s2_ff <= 1'b1;
		end else begin
			cnv_s1_ff <= LINK.conversion_start_pin;
			cnv_s2_ff <= cnv_s1_ff;
			cnv_s3_ff <= cnv_s2_ff;
			din_s1_ff <= LINK.din;
			din_s2_ff <= din_s1_ff;
		end
	end

	// both pins see the same latency, so the input level held
	// through the start edge is still valid at the detected edge
	assign cnv_rise = cnv_s2_ff & ~cnv_s3_ff;

	// ==========================================================
	// conversion engine on the internal clock
	sar_dev_state_type            state_ff;
	logic [CNT_W-1:0]             conv_cnt_ff;
	logic [DATA_W-1:0]            sample_ff;
	logic [DATA_W-1:0]            result_ff;
	logic                         mode_ff;
	logic                         daisy_ff;
	logic                         ready_ff;
	logic                         overrun_ff;
	logic                         conv_end;

	assign conv_end = (state_ff == D_CONV) && (conv_cnt_ff == DEV_CONV_CYC - 7'h01);

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			state_ff <= D_ACQ;
		end else begin
			case (state_ff)
				D_ACQ: begin
					if (cnv_rise) begin
						state_ff <= D_CONV;
					end
				end
				D_CONV: begin
					if (conv_end) begin
						state_ff <= D_ACQ;
					end
				end
				default: begin
					state_ff <= D_ACQ;
				end
			endcase
		end
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			conv_cnt_ff <= 7'h00;
		end else if (state_ff == D_CONV) begin
			conv_cnt_ff <= conv_cnt_ff + 7'h01;
		end else begin
			conv_cnt_ff <= 7'h00;
		end
	end

	// sample is frozen at the start edge, result appears at the end
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			sample_ff <= 16'h0000;
		end else if (cnv_rise && (state_ff == D_ACQ)) begin
			sample_ff <= ANALOG_CODE;
		end
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			result_ff <= 16'h0000;
		end else if (conv_end) begin
			result_ff <= sample_ff;
		end
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			mode_ff  <= SEL_CS;
			daisy_ff <= 1'b0;
		end else if (cnv_rise && (state_ff == D_ACQ)) begin
			mode_ff  <= din_s2_ff;
			daisy_ff <= (din_s2_ff == SEL_DAISY);
		end
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			ready_ff <= 1'b0;
		end else if (conv_end) begin
			ready_ff <= 1'b1;
		end else if (cnv_rise) begin
			ready_ff <= 1'b0;
		end
	end

	// a start edge inside a conversion is dropped and flagged
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			overrun_ff <= 1'b0;
		end else if (cnv_rise && (state_ff == D_CONV)) begin
			overrun_ff <= 1'b1;
		end else if (cnv_rise) begin
			overrun_ff <= 1'b0;
		end
	end

	// ==========================================================
	// frame select from raw pins
	// mode_ff changes only at an accepted start edge and result_ff only at conversion end,
	// both of which the host keeps apart from any readout, so they are still during a frame
	logic frame_sel;
	logic frame_clr_n;

	always_comb begin
		if (mode_ff == SEL_DAISY) begin
			frame_sel = ~LINK.conversion_start_pin;
		end else begin
			// 3-wire: start pin low with input high; 4-wire: input low
			// with start pin high
			frame_sel = LINK.conversion_start_pin ^ LINK.din;
		end
	end

	assign frame_clr_n = frame_sel & RESETN;

	// ==========================================================
	// readout shifter on falling link clock edges
	logic [4:0]        bit_cnt_ff;
	logic [DATA_W-1:0] shift_ff;
	logic              done_tgl_ff;
	logic              frame_end;

	// cleared by the frame's own select, so no clock edge is needed
	// after the frame for the shifter to be ready for the next one
	always_ff @(negedge LINK.sclk or negedge frame_clr_n) begin
		if (!frame_clr_n) begin
			bit_cnt_ff <= 5'h00;
		end else if (bit_cnt_ff != FRAME_BITS) begin
			bit_cnt_ff <= bit_cnt_ff + 5'h01;
		end
	end

	always_ff @(negedge LINK.sclk or negedge frame_clr_n) begin
		if (!frame_clr_n) begin
			shift_ff <= 16'h0000;
		end else if (bit_cnt_ff == 5'h00) begin
			shift_ff <= {result_ff[DATA_W-2:0], LINK.din};
		end else begin
			shift_ff <= {shift_ff[DATA_W-2:0], LINK.din};
		end
	end

	assign frame_end = (bit_cnt_ff == FRAME_BITS - 5'h01);

	// one toggle per completed frame, taken over by CLK below
	always_ff @(negedge LINK.sclk or negedge RESETN) begin
		if (!RESETN) begin
			done_tgl_ff <= 1'b0;
		end else if (frame_sel && frame_end) begin
			done_tgl_ff <= ~done_tgl_ff;
		end
	end

	// ==========================================================
	// serial output drive
	// the enable path is kept combinational from the pins: a flop on
	// either clock could not meet the few-ns enable and release times
	logic out_en;

	always_comb begin
		if (mode_ff == SEL_DAISY) begin
			out_en = frame_sel;
		end else begin
			out_en = frame_sel && (bit_cnt_ff != FRAME_BITS);
		end
	end

	assign LINK.dout_oe_n = ~out_en;
	// before the first falling edge the MSB comes straight from the result
	assign LINK.dout = (bit_cnt_ff == 5'h00) ? result_ff[DATA_W-1] : shift_ff[DATA_W-1];

	// ==========================================================
	// frame-done event back into CLK
	logic done_s1_ff;
	logic done_s2_ff;
	logic done_s3_ff;
	logic read_done_ff;

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			done_s1_ff   <= 1'b0;
			done_s2_ff   <= 1'b0;
			done_s3_ff   <= 1'b0;
			read_done_ff <= 1'b0;
		end else begin
			done_s1_ff   <= done_tgl_ff;
			done_s2_ff   <= done_s1_ff;
			done_s3_ff   <= done_s2_ff;
			read_done_ff <= done_s2_ff ^ done_s3_ff;
		end
	end

	// ==========================================================
	// user-side status, all registered
	logic busy_ff;
	logic track_ff;

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			busy_ff  <= 1'b0;
			track_ff <= 1'b1;
		end else begin
			// raised with the accepted start edge so busy spans the whole conversion
			busy_ff  <= ((state_ff == D_ACQ) && cnv_rise) || ((state_ff == D_CONV) && !conv_end);
			track_ff <= ((state_ff == D_ACQ) && !cnv_rise) || conv_end;
		end
	end

	assign CONV_BUSY     = busy_ff;
	assign TRACK_ENABLE  = track_ff;
	assign POWER_DOWN    = track_ff;
	assign MODE_DAISY    = daisy_ff;
	assign RESULT_READY  = ready_ff;
	assign READ_DONE     = read_done_ff;
	assign START_OVERRUN = overrun_ff;

endmodule

// ===== src/sar_host.sv
// host end: start sequencing, divided serial clock and result capture
`timescale 1ns/1ps
module sar_host
	import sar_pkg::*;
(
	input  wire logic                       CLK,
	input  wire logic                       RESETN,
	sar_link_if.host                        LINK,
	input  wire logic                       START,
	input  wire sar_pkg::sar_mode_type      MODE,
	output logic                            BUSY,
	output logic [sar_pkg::DATA_W-1:0]      RX_DATA,
	output logic                            RX_VALID
);
	import sar_pkg::*;

	// ==========================================================
	// serial output synchroniser
	logic dout_s1_ff;
	logic dout_s2_ff;

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			dout_s1_ff <= 1'b0;
			dout_s2_ff <= 1'b0;
		end else begin
			dout_s1_ff <= LINK.dout_line;
			dout_s2_ff <= dout_s1_ff;
		end
	end

	// ==========================================================
	// sequencer
	sar_host_state_type state_ff;
	sar_mode_type       mode_ff;
	logic [CNT_W-1:0]   tmr_ff;
	logic [CNT_W-1:0]   period_ff;
	logic [1:0]         ph_ff;
	logic [4:0]         bit_ff;
	logic               last_bit;

	assign last_bit = (ph_ff == 2'h3) && (bit_ff == FRAME_BITS - 5'h01);

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			state_ff <= H_IDLE;
		end else begin
			case (state_ff)
				H_IDLE: begin
					if (START) begin
						state_ff <= H_SETUP;
					end
				end
				H_SETUP: begin
					if (tmr_ff == SETUP_CYC - 7'h01) begin
						state_ff <= H_CONV;
					end
				end
				H_CONV: begin
					if (tmr_ff == CONV_CYC - 7'h01) begin
						state_ff <= H_SEL;
					end
				end
				H_SEL: begin
					if (tmr_ff == SEL_WAIT_CYC - 7'h01) begin
						state_ff <= H_SHIFT;
					end
				end
				H_SHIFT: begin
					if (last_bit) begin
						state_ff <= H_DESEL;
					end
				end
				H_DESEL: begin
					state_ff <= H_WAIT;
				end
				H_WAIT: begin
					if ((period_ff == CYCLE_CYC) && (tmr_ff >= ACQ_CYC)) begin
						state_ff <= H_IDLE;
					end
				end
				default: begin
					state_ff <= H_IDLE;
				end
			endcase
		end
	end

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			mode_ff <= MODE_3WIRE;
		end else if ((state_ff == H_IDLE) && START) begin
			mode_ff <= MODE;
		end
	end

	// phase timer; in WAIT it keeps counting acquisition time since SEL
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			tmr_ff <= 7'h00;
		end else if ((state_ff == H_SETUP) && (tmr_ff == SETUP_CYC - 7'h01)) begin
			tmr_ff <= 7'h00;
		end else if ((state_ff == H_CONV) && (tmr_ff == CONV_CYC - 7'h01)) begin
			tmr_ff <= 7'h00;
		end else if ((state_ff == H_IDLE) || (tmr_ff == 7'h7f)) begin
			tmr_ff <= (state_ff == H_IDLE) ? 7'h00 : tmr_ff;
		end else begin
			tmr_ff <= tmr_ff + 7'h01;
		end
	end

	// time since the start edge, or since DESEL in every mode, saturating at the cycle minimum; the start pin
	// rising to close a 3-wire or daisy frame launches a conversion as well
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			period_ff <= 7'h00;
		end else if ((state_ff == H_SETUP) || (state_ff == H_IDLE) || (state_ff == H_DESEL)) begin
			period_ff <= 7'h00;
		end else if (period_ff != CYCLE_CYC) begin
			period_ff <= period_ff + 7'h01;
		end
	end

	// ==========================================================
	// divide-by-four serial clock: 200 ns, even halves
	logic               sclk_ff;
	logic [DATA_W-1:0]  rx_sh_ff;

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			ph_ff   <= 2'h0;
			bit_ff  <= 5'h00;
			sclk_ff <= 1'b0;
		end else if (state_ff == H_SHIFT) begin
			ph_ff   <= ph_ff + 2'h1;
			bit_ff  <= (ph_ff == 2'h3) ? bit_ff + 5'h01 : bit_ff;
			sclk_ff <= (ph_ff == 2'h0) ? 1'b1 : ((ph_ff == 2'h2) ? 1'b0 : sclk_ff);
		end else begin
			ph_ff   <= 2'h0;
			bit_ff  <= 5'h00;
			sclk_ff <= 1'b0;
		end
	end

	// sample the synced bit just as the falling edge is issued
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			rx_sh_ff <= 16'h0000;
		end else if ((state_ff == H_SHIFT) && (ph_ff == 2'h2)) begin
			rx_sh_ff <= {rx_sh_ff[DATA_W-2:0], dout_s2_ff};
		end
	end

	// ==========================================================
	// pin drive
	logic cnv_ff;
	logic din_ff;
	logic sel_low;

	assign sel_low = (state_ff == H_SEL) || (state_ff == H_SHIFT);

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			cnv_ff <= 1'b1;
			din_ff <= 1'b1;
		end else begin
			case (state_ff)
				H_SETUP: begin
					cnv_ff <= 1'b0;
					din_ff <= (mode_ff == MODE_DAISY) ? SEL_DAISY : SEL_CS;
				end
				H_SEL, H_SHIFT: begin
					cnv_ff <= (mode_ff == MODE_4WIRE) ? 1'b1 : ~sel_low;
					din_ff <= (mode_ff == MODE_4WIRE) ? 1'b0 :
						((mode_ff == MODE_DAISY) ? SEL_DAISY : SEL_CS);
				end
				default: begin
					cnv_ff <= 1'b1;
					din_ff <= (mode_ff == MODE_DAISY) ? SEL_DAISY : SEL_CS;
				end
			endcase
		end
	end

	// ==========================================================
	// user side
	logic              busy_ff;
	logic              rx_valid_ff;
	logic [DATA_W-1:0] rx_data_ff;

	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			busy_ff     <= 1'b0;
			rx_valid_ff <= 1'b0;
			rx_data_ff  <= 16'h0000;
		end else begin
			busy_ff     <= (state_ff != H_IDLE) || START;
			rx_valid_ff <= (state_ff == H_DESEL);
			if (state_ff == H_DESEL) begin
				rx_data_ff <= rx_sh_ff;
			end
		end
	end

	assign LINK.conversion_start_pin = cnv_ff;
	assign LINK.din                  = din_ff;
	assign LINK.sclk                 = sclk_ff;
	assign BUSY                      = busy_ff;
	assign RX_VALID                  = rx_valid_ff;
	assign RX_DATA                   = rx_data_ff;

endmodule

// ===== dv/sar_link_sva.sv
// concurrent checks on the pins between converter and host controller
`timescale 1ns/1ps
module sar_link_sva (
	input wire logic CLK,
	input wire logic RESETN,
	input wire logic conversion_start_pin,
	input wire logic sclk,
	input wire logic din,
	input wire logic dout,
	input wire logic dout_oe_n
);
	logic [4:0] fall_cnt_ff;

	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!RESETN);

	// ==========================================================
	// falling link clock edges seen while the output is driven
	always_ff @(posedge CLK or negedge RESETN) begin
		if (!RESETN) begin
			fall_cnt_ff <= 5'h0;
		end else if (dout_oe_n) begin
			fall_cnt_ff <= 5'h0;
		end else if ($fell(sclk)) begin
			fall_cnt_ff <= fall_cnt_ff + 5'h1;
		end
	end

	// ==========================================================
	// link clock shape: two cycles high, then two low
	sequence clk_high_s;
		sclk [*2];
	endsequence
	sequence clk_low_s;
		!sclk [*2];
	endsequence

	// ==========================================================
	// pin relations
	chk_cs3_select_drives: assert property (
		$fell(conversion_start_pin) && din |-> !dout_oe_n)
		else $error("output not driven after start pin low");
	chk_cs4_select_drives: assert property (
		$fell(din) && conversion_start_pin |-> !dout_oe_n)
		else $error("output not driven after serial input low");
	chk_both_high_release: assert property (
		conversion_start_pin && din |-> dout_oe_n)
		else $error("output driven while deselected");
	// the sixteenth fall is seen one edge late, so the count still shows fifteen
	chk_frame_end_release: assert property (
		(conversion_start_pin != din) && $fell(sclk) && fall_cnt_ff == 5'hf
		|-> dout_oe_n)
		else $error("output still driven after last falling edge");
	chk_bit_on_fall: assert property (
		!dout_oe_n && !$past(dout_oe_n) && $changed(dout) |-> $fell(sclk))
		else $error("output bit changed without a falling link clock");
	chk_clk_still_start: assert property (
		$rose(conversion_start_pin) |-> !sclk && !$past(sclk))
		else $error("link clock moved around conversion start");
	chk_din_held_start: assert property (
		$rose(conversion_start_pin) |-> $stable(din))
		else $error("serial input changed at conversion start");
	chk_clk_phase_shape: assert property (
		$rose(sclk) |-> clk_high_s ##1 clk_low_s)
		else $error("link clock phases not balanced");
endmodule

// ===== dv/sar_adc_serial_readout_test.sv
// self-checking bench: host and converter joined across the link
`timescale 1ns/1ps
module sar_adc_serial_readout_test;
	import sar_pkg::*;

	logic              clk = 1'b0;
	logic              rst_n = 1'b0;
	logic              start = 1'b0;
	sar_mode_type      mode = MODE_3WIRE;
	logic [DATA_W-1:0] code = 16'h0000;
	logic              busy, rx_valid, conv_busy, track_en, pwr_down;
	logic              mode_daisy, res_ready, read_done, overrun;
	logic [DATA_W-1:0] rx_data;
	int                n_mismatch = 0;
	int                num_checks = 0;
	int                busy_cyc, rises, dones, got, n;
	logic              prev_sck;
	integer            seed = 32'hfd635341;
	sar_mode_type      modes [3] = '{MODE_3WIRE, MODE_4WIRE, MODE_DAISY};
	logic [15:0]       corners [4] = '{16'h0000, 16'hffff, 16'h8001, 16'h5a5a};

	always #25 clk = ~clk;

	sar_link_if u_sar_link_if ();

	sar_dev u_sar_dev (.CLK(clk), .RESETN(rst_n), .LINK(u_sar_link_if.dev),
		.ANALOG_CODE(code), .CONV_BUSY(conv_busy), .TRACK_ENABLE(track_en),
		.POWER_DOWN(pwr_down), .MODE_DAISY(mode_daisy), .RESULT_READY(res_ready),
		.READ_DONE(read_done), .START_OVERRUN(overrun));

	sar_host u_sar_host (.CLK(clk), .RESETN(rst_n), .LINK(u_sar_link_if.host),
		.START(start), .MODE(mode), .BUSY(busy), .RX_DATA(rx_data), .RX_VALID(rx_valid));

	sar_link_sva u_sar_link_sva (.CLK(clk), .RESETN(rst_n),
		.conversion_start_pin(u_sar_link_if.conversion_start_pin),
		.sclk(u_sar_link_if.sclk), .din(u_sar_link_if.din),
		.dout(u_sar_link_if.dout), .dout_oe_n(u_sar_link_if.dout_oe_n));

	// ==========================================================
	// expectations and reporting
	function automatic logic [DATA_W-1:0] exp_flag(input logic b);
		return {15'h0000, b};
	endfunction

	// a frame closed by the start pin rising launches a second conversion
	function automatic logic [DATA_W-1:0] exp_conv(input sar_mode_type m);
		return (m == MODE_4WIRE) ? 16'(DEV_CONV_CYC) : 16'(2 * DEV_CONV_CYC);
	endfunction

	task automatic check(input string what, input logic [DATA_W-1:0] seen,
		input logic [DATA_W-1:0] exp);
		num_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("BAD %s expected %h seen %h", what, exp, seen);
		end
	endtask

	task automatic complete_run;
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("TEST PASSED");
		end else begin
			$display("TEST FAILED");
		end
		$finish;
	endtask

	// ==========================================================
	// one clock step, tallying what the link and converter show
	task automatic step;
		@(posedge clk);
		#2;
		busy_cyc += int'(conv_busy === 1'b1);
		dones += int'(read_done === 1'b1);
		got += int'(rx_valid === 1'b1);
		rises += int'(u_sar_link_if.sclk === 1'b1 && prev_sck !== 1'b1);
		prev_sck = u_sar_link_if.sclk;
	endtask

	// one full conversion and readout; poke repeats START while busy
	task automatic run(input sar_mode_type m, input logic [DATA_W-1:0] c, input bit poke);
		busy_cyc = 0;
		rises = 0;
		dones = 0;
		got = 0;
		n = 0;
		prev_sck = u_sar_link_if.sclk;
		mode = m;
		code = c;
		start = 1'b1;
		step;
		start = 1'b0;
		while (n < 400 && !(got > 0 && busy === 1'b0)) begin
			step;
			n++;
			start = poke && n == 5;
			if (rx_valid === 1'b1) begin
				check("rx_data", rx_data, c);
			end
		end
		start = 1'b0;
		// the frame-done pulse crosses domains and may trail the host
		repeat (4) step;
		if (n >= 400) begin
			check("timeout", 16'h0001, 16'h0000);
			return;
		end
		check("rx_count", 16'(got), 16'h0001);
		check("overrun", exp_flag(overrun), 16'h0000);
		check("conv_cycles", 16'(busy_cyc), exp_conv(m));
		check("ready", exp_flag(res_ready), 16'h0001);
		check("track", exp_flag(track_en), 16'h0001);
		check("power_down", exp_flag(pwr_down), 16'h0001);
		check("clk_pulses", 16'(rises), 16'(FRAME_BITS));
		check("frame_done", 16'(dones), 16'h0001);
		check("mode_daisy", exp_flag(mode_daisy), exp_flag(m == MODE_DAISY));
		check("released", exp_flag(u_sar_link_if.dout_oe_n), 16'h0001);
		check("clk_idle", exp_flag(u_sar_link_if.sclk), 16'h0000);
		$display("test mode %0d code %h finished", m, c);
	endtask

	// ==========================================================
	// main sequence: corner codes in every mode, then random traffic
	initial begin
		repeat (10) @(posedge clk);
		#2;
		rst_n = 1'b1;
		step;
		for (int i = 0; i < 4; i++) begin
			for (int k = 0; k < 3; k++) begin
				run(modes[k], corners[i], i == 1);
			end
		end
		for (int i = 0; i < 12; i++) begin
			run(modes[$unsigned($random(seed)) % 3], 16'($random(seed)), 1'b0);
		end
		complete_run;
	end
endmodule
